// file: inc/prcer_pkg.sv
// Purpose: constants for the peripheral reset and clock gate registers
// Assumes: byte addresses on the register port, 32-bit data
// Notes: shared by the register bank and its two leaf modules
package prcer_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W = 4;
    localparam int unsigned LANE_W = 8;

    localparam logic [7:0] RST_ONE_OFFSET = 8'h10;
    localparam logic [7:0] CLK_GATE_OFFSET = 8'h14;

    localparam logic [31:0] RST_ONE_RESET = 32'h00000000;
    localparam logic [31:0] RST_ONE_MASK = 32'h12220913;
    localparam logic [31:0] CLK_GATE_RESET = 32'h00000014;
    localparam logic [31:0] CLK_GATE_MASK = 32'h00000015;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;

    localparam int unsigned TIMER_TWO_RESET_BIT = 0;
    localparam int unsigned TIMER_THREE_RESET_BIT = 1;
    localparam int unsigned TIMER_SIX_RESET_BIT = 4;
    localparam int unsigned TIMER_FOURTEEN_RESET_BIT = 8;
    localparam int unsigned WINDOW_WATCHDOG_RESET_BIT = 11;
    localparam int unsigned SECOND_SERIAL_PORT_RESET_BIT = 17;
    localparam int unsigned TWO_WIRE_BUS_RESET_BIT = 21;
    localparam int unsigned CAN_CONTROLLER_RESET_BIT = 25;
    localparam int unsigned POWER_INTERFACE_RESET_BIT = 28;

    localparam int unsigned DMA_CLOCK_GATE_BIT = 0;
    localparam int unsigned SRAM_CLOCK_GATE_BIT = 2;
    localparam int unsigned BIT_FOUR_CLOCK_GATE_BIT = 4;

endpackage : prcer_pkg

// file: verilog/prcer_reg32.sv
// Purpose: one 32-bit control register with byte lane writes
// Assumes: one clock, synchronous active-high reset
// Notes: bits outside the write mask stay at zero
module prcer_reg32
    import prcer_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = 32'h00000000,
    parameter logic [31:0] WR_MASK = 32'hFFFFFFFF
) (
    input logic clk,
    input logic sys_rst,
    input logic clk_en,
    input logic wr_en,
    input logic [BE_W-1:0] wr_be,
    input logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] q
);

    logic [DATA_W-1:0] reg_q;

    // byte lanes let half word and byte writes land alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_q <= RESET_VAL & WR_MASK;
        end else if (clk_en && wr_en) begin
            for (int i = 0; i < BE_W; i++) begin
                if (wr_be[i]) begin
                    reg_q[i*LANE_W +: LANE_W] <=
                        wr_data[i*LANE_W +: LANE_W] & WR_MASK[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign q = reg_q;

endmodule : prcer_reg32

// file: verilog/prcer_rd_gate.sv
// Purpose: zero the readback of a peripheral whose clock is gated off
// Assumes: peripheral read data valid in the cycle it is sampled
// Notes: registered, so gated data trail the source by one cycle
module prcer_rd_gate
    import prcer_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    input logic clk_en,
    input logic gate_on,
    input logic [DATA_W-1:0] periph_rdata,
    output logic [DATA_W-1:0] gated_rdata
);

    logic [DATA_W-1:0] gated_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gated_q <= ZERO_WORD;
        end else if (clk_en) begin
            gated_q <= gate_on ? periph_rdata : ZERO_WORD;
        end
    end

    assign gated_rdata = gated_q;

endmodule : prcer_rd_gate

// file: verilog/prcer_regs.sv
// Purpose: peripheral reset and memory-side clock gate registers
// Assumes: plain register port, read data one cycle after read strobe
// Notes: clk_en low freezes every register, including read data
//
// Local design decision: the address-and-strobe port.
module prcer_regs
    import prcer_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    input logic clk_en,
    input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wr_data,
    input logic [BE_W-1:0] wr_be,
    input logic wr_stb,
    input logic rd_stb,
    output logic [DATA_W-1:0] rd_data,
    input logic [DATA_W-1:0] dma_periph_rdata,
    output logic [DATA_W-1:0] dma_gated_rdata,
    output logic timer_two_reset,
    output logic timer_three_reset,
    output logic timer_six_reset,
    output logic timer_fourteen_reset,
    output logic window_watchdog_reset,
    output logic second_serial_port_reset,
    output logic two_wire_bus_reset,
    output logic can_controller_reset,
    output logic power_interface_reset,
    output logic dma_clock_enable,
    output logic sram_clock_enable,
    output logic bit_four_clock_enable
);

    logic sel_rst_one;
    logic sel_clk_gate;
    logic [DATA_W-1:0] rst_one_q;
    logic [DATA_W-1:0] clk_gate_q;
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;

    // address decode
    assign sel_rst_one = (addr == RST_ONE_OFFSET);
    assign sel_clk_gate = (addr == CLK_GATE_OFFSET);

    // reset register, zero after system reset
    prcer_reg32 #(
        .RESET_VAL(RST_ONE_RESET),
        .WR_MASK(RST_ONE_MASK)
    ) u_rst_one (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(wr_stb && sel_rst_one),
        .wr_be(wr_be),
        .wr_data(wr_data),
        .q(rst_one_q)
    );

    // clock gate register, bits 2 and 4 start on
    prcer_reg32 #(
        .RESET_VAL(CLK_GATE_RESET),
        .WR_MASK(CLK_GATE_MASK)
    ) u_clk_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(wr_stb && sel_clk_gate),
        .wr_be(wr_be),
        .wr_data(wr_data),
        .q(clk_gate_q)
    );

    // reset outputs are levels of their control bits
    assign timer_two_reset = rst_one_q[TIMER_TWO_RESET_BIT];
    assign timer_three_reset = rst_one_q[TIMER_THREE_RESET_BIT];
    assign timer_six_reset = rst_one_q[TIMER_SIX_RESET_BIT];
    assign timer_fourteen_reset = rst_one_q[TIMER_FOURTEEN_RESET_BIT];
    assign window_watchdog_reset = rst_one_q[WINDOW_WATCHDOG_RESET_BIT];
    assign second_serial_port_reset = rst_one_q[SECOND_SERIAL_PORT_RESET_BIT];
    assign two_wire_bus_reset = rst_one_q[TWO_WIRE_BUS_RESET_BIT];
    assign can_controller_reset = rst_one_q[CAN_CONTROLLER_RESET_BIT];
    assign power_interface_reset = rst_one_q[POWER_INTERFACE_RESET_BIT];

    // clock gate outputs
    assign dma_clock_enable = clk_gate_q[DMA_CLOCK_GATE_BIT];
    assign sram_clock_enable = clk_gate_q[SRAM_CLOCK_GATE_BIT];
    assign bit_four_clock_enable = clk_gate_q[BIT_FOUR_CLOCK_GATE_BIT];

    // dma readback forced to zero while its clock is off
    prcer_rd_gate u_dma_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .gate_on(clk_gate_q[DMA_CLOCK_GATE_BIT]),
        .periph_rdata(dma_periph_rdata),
        .gated_rdata(dma_gated_rdata)
    );

    // read mux, unmapped addresses read zero
    always_comb begin
        rd_data_d = ZERO_WORD;
        if (rd_stb) begin
            if (sel_rst_one) begin
                rd_data_d = rst_one_q & RST_ONE_MASK;
            end else if (sel_clk_gate) begin
                rd_data_d = clk_gate_q & CLK_GATE_MASK;
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= ZERO_WORD;
        end else if (clk_en) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic past_valid_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    a_rst_reg_zero: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> (rst_one_q == RST_ONE_RESET)
    ) else $error("reset register not zero after reset");

    a_gate_reset_val: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> (clk_gate_q == CLK_GATE_RESET)
            && sram_clock_enable && bit_four_clock_enable && !dma_clock_enable
    ) else $error("clock gate register wrong after reset");

    a_timer_two_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[0]
        |=> timer_two_reset == $past(wr_data[TIMER_TWO_RESET_BIT])
    ) else $error("timer two reset not following write");

    a_byte_lane_keep: assert property (
        clk_en && wr_stb && sel_rst_one && !wr_be[3]
        |=> can_controller_reset == $past(can_controller_reset)
            && power_interface_reset == $past(power_interface_reset)
    ) else $error("unselected byte lane changed");

    a_reset_hold: assert property (
        timer_six_reset && !(wr_stb && sel_rst_one)
        |=> timer_six_reset
    ) else $error("timer six reset dropped without write");

    a_rsvd_zero: assert property (
        (rst_one_q & ~RST_ONE_MASK) == ZERO_WORD
        && (clk_gate_q & ~CLK_GATE_MASK) == ZERO_WORD
    ) else $error("reserved bit set");

    a_rd_reset_reg: assert property (
        clk_en && rd_stb && sel_rst_one
        |=> rd_data == {3'h0, power_interface_reset, 2'h0,
            can_controller_reset, 3'h0, two_wire_bus_reset, 3'h0,
            second_serial_port_reset, 5'h00, window_watchdog_reset, 2'h0,
            timer_fourteen_reset, 3'h0, timer_six_reset, 2'h0,
            timer_three_reset, timer_two_reset}
    ) else $error("reset register readback wrong");

    a_rd_idle_zero: assert property (
        clk_en && !rd_stb |=> rd_data == ZERO_WORD
    ) else $error("read data outside read slot");

    a_gate_write: assert property (
        clk_en && wr_stb && sel_clk_gate && wr_be[0]
        |=> dma_clock_enable == $past(wr_data[DMA_CLOCK_GATE_BIT])
            && sram_clock_enable == $past(wr_data[SRAM_CLOCK_GATE_BIT])
    ) else $error("clock gate bits not writable");

    a_dma_gate_zero: assert property (
        clk_en && !dma_clock_enable |=> dma_gated_rdata == ZERO_WORD
    ) else $error("gated dma read not zero");

    a_dma_gate_pass: assert property (
        past_valid_q && clk_en && dma_clock_enable
        |=> dma_gated_rdata == $past(dma_periph_rdata)
    ) else $error("enabled dma read not passed");

    a_timer_three_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[0]
        |=> timer_three_reset == $past(wr_data[TIMER_THREE_RESET_BIT])
    ) else $error("timer three reset not following write");

    a_timer_six_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[0]
        |=> timer_six_reset == $past(wr_data[TIMER_SIX_RESET_BIT])
    ) else $error("timer six reset not following write");

    a_timer_fourteen_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[1]
        |=> timer_fourteen_reset == $past(wr_data[TIMER_FOURTEEN_RESET_BIT])
    ) else $error("timer fourteen reset not following write");

    a_watchdog_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[1]
        |=> window_watchdog_reset == $past(wr_data[WINDOW_WATCHDOG_RESET_BIT])
    ) else $error("watchdog reset not following write");

    a_serial_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[2]
        |=> second_serial_port_reset == $past(wr_data[SECOND_SERIAL_PORT_RESET_BIT])
    ) else $error("serial port reset not following write");

    a_two_wire_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[2]
        |=> two_wire_bus_reset == $past(wr_data[TWO_WIRE_BUS_RESET_BIT])
    ) else $error("two-wire reset not following write");

    a_can_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[3]
        |=> can_controller_reset == $past(wr_data[CAN_CONTROLLER_RESET_BIT])
    ) else $error("can reset not following write");

    a_power_set: assert property (
        clk_en && wr_stb && sel_rst_one && wr_be[3]
        |=> power_interface_reset == $past(wr_data[POWER_INTERFACE_RESET_BIT])
    ) else $error("power interface reset not following write");

    a_lane_zero_keep: assert property (
        clk_en && wr_stb && sel_rst_one && !wr_be[0]
        |=> timer_two_reset == $past(timer_two_reset)
            && timer_three_reset == $past(timer_three_reset)
            && timer_six_reset == $past(timer_six_reset)
    ) else $error("byte lane zero changed");

    a_lane_one_keep: assert property (
        clk_en && wr_stb && sel_rst_one && !wr_be[1]
        |=> timer_fourteen_reset == $past(timer_fourteen_reset)
            && window_watchdog_reset == $past(window_watchdog_reset)
    ) else $error("byte lane one changed");

    a_lane_two_keep: assert property (
        clk_en && wr_stb && sel_rst_one && !wr_be[2]
        |=> second_serial_port_reset == $past(second_serial_port_reset)
            && two_wire_bus_reset == $past(two_wire_bus_reset)
    ) else $error("byte lane two changed");

    a_gate_lane_keep: assert property (
        clk_en && wr_stb && sel_clk_gate && !wr_be[0]
        |=> $stable(clk_gate_q)
    ) else $error("clock gate changed without lane zero");

    a_gate_bit_four: assert property (
        clk_en && wr_stb && sel_clk_gate && wr_be[0]
        |=> bit_four_clock_enable == $past(wr_data[BIT_FOUR_CLOCK_GATE_BIT])
    ) else $error("clock gate bit four not writable");

    a_rd_gate_reg: assert property (
        clk_en && rd_stb && sel_clk_gate
        |=> rd_data == {27'h0000000, bit_four_clock_enable, 1'h0,
            sram_clock_enable, 1'h0, dma_clock_enable}
    ) else $error("clock gate readback wrong");

    a_rd_unmapped: assert property (
        clk_en && rd_stb && !sel_rst_one && !sel_clk_gate
        |=> rd_data == ZERO_WORD
    ) else $error("unmapped read not zero");

    a_unmapped_write: assert property (
        clk_en && wr_stb && !sel_rst_one && !sel_clk_gate
        |=> $stable(rst_one_q) && $stable(clk_gate_q)
    ) else $error("unmapped write changed a register");

    a_freeze_regs: assert property (
        !clk_en |=> $stable(rst_one_q) && $stable(clk_gate_q)
    ) else $error("register changed while frozen");

    a_freeze_read: assert property (
        !clk_en |=> $stable(rd_data) && $stable(dma_gated_rdata)
    ) else $error("read data changed while frozen");

    c_frozen_write: cover property (
        !clk_en && wr_stb && sel_rst_one
    );

    c_reset_pulse: cover property (
        wr_stb && sel_rst_one && wr_be[0] && wr_data[TIMER_TWO_RESET_BIT]
        ##1 timer_two_reset ##[1:20] !timer_two_reset
    );

    c_byte_write: cover property (
        clk_en && wr_stb && sel_clk_gate && wr_be == 4'h1
    );

    c_read_after_write: cover property (
        wr_stb && sel_clk_gate ##1 rd_stb && sel_clk_gate
    );

    c_dma_gated: cover property (
        !dma_clock_enable && dma_periph_rdata != ZERO_WORD
    );

endmodule : prcer_regs

// file: tb/prcer_dma_model.sv
// Purpose: dma controller read data behind the clock gate
// Assumes: one clock, synchronous active-high reset
// Notes: data change every cycle so stale values show
module prcer_dma_model (
    input wire logic clk,
    input wire logic sys_rst,
    output logic [31:0] rdata_q
);
    timeunit 1ns;
    timeprecision 1ns;
    // rotating pattern, never constant
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 32'hA5C3961E;
        end else begin
            rdata_q <= {rdata_q[30:0], rdata_q[31]} ^ 32'h00010203;
        end
    end
endmodule : prcer_dma_model

// file: tb/testbench.sv
// Purpose: self-checking bench for the reset and clock gate registers
// Assumes: bench drives inputs by nba just after rising edges
// Notes: outputs checked at the falling edge
`define CHK(nm, e, s) begin total_checks++; if ((e) !== (s)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import prcer_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h00000000;
    logic [3:0] wr_be = 4'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rd_data, dma_rdata, dma_gated, p;
    logic t2, t3, t6, t14, wd, sp, tw, cn, pw, de, se, fe;
    logic [8:0] rv;
    logic [2:0] ev;
    int n_errors = 0;
    int total_checks = 0;
    int pos [9] = '{0, 1, 4, 8, 11, 17, 21, 25, 28};
    assign rv = {pw, cn, tw, sp, wd, t14, t6, t3, t2};
    assign ev = {fe, se, de};
    prcer_regs i_prcer_regs (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .addr(addr),
        .wr_data(wr_data),
        .wr_be(wr_be),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rd_data(rd_data),
        .dma_periph_rdata(dma_rdata),
        .dma_gated_rdata(dma_gated),
        .timer_two_reset(t2),
        .timer_three_reset(t3),
        .timer_six_reset(t6),
        .timer_fourteen_reset(t14),
        .window_watchdog_reset(wd),
        .second_serial_port_reset(sp),
        .two_wire_bus_reset(tw),
        .can_controller_reset(cn),
        .power_interface_reset(pw),
        .dma_clock_enable(de),
        .sram_clock_enable(se),
        .bit_four_clock_enable(fe)
    );
    prcer_dma_model i_prcer_dma_model (
        .clk(clk),
        .sys_rst(sys_rst),
        .rdata_q(dma_rdata)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_be <= be;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        `CHK("rd_data", e, rd_data)
    endtask : rd
    task automatic chk_reset;
        rd(8'h10, 32'h00000000);
        rd(8'h14, 32'h00000014);
        `CHK("enables", 3'b110, ev)
        `CHK("resets", 9'h000, rv)
    endtask : chk_reset
    task automatic dchk(input logic on);
        repeat (4) begin
            p = dma_rdata;
            @(negedge clk);
            `CHK("dma_gated", on ? p : 32'h0, dma_gated)
        end
    endtask : dchk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #(3000 * 100);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        chk_reset();
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            wr(8'h10, 32'h1 << pos[i], 4'hF);
            `CHK("resets", 9'h1 << i, rv)
            rd(8'h10, 32'h1 << pos[i]);
        end
        wr(8'h10, 32'hFFFFFFFF, 4'h2);
        rd(8'h10, 32'h10000900);
        wr(8'h10, 32'hFFFFFFFF, 4'hC);
        rd(8'h10, 32'h12220900);
        wr(8'h10, 32'hFFFFFFFF, 4'h1);
        `CHK("resets", 9'h1FF, rv)
        rd(8'h10, 32'h12220913);
        wr(8'h10, 32'h00000000, 4'hF);
        `CHK("resets", 9'h000, rv)
        $display("test reset register done");
        wr(8'h14, 32'hFFFFFFFF, 4'hF);
        rd(8'h14, 32'h00000015);
        `CHK("enables", 3'b111, ev)
        dchk(1'b1);
        wr(8'h14, 32'h00000000, 4'hF);
        `CHK("enables", 3'b000, ev)
        dchk(1'b0);
        wr(8'h14, 32'h00000001, 4'h3);
        rd(8'h14, 32'h00000001);
        $display("test clock gate done");
        wr(8'h18, 32'hFFFFFFFF, 4'hF);
        rd(8'h18, 32'h00000000);
        rd(8'h10, 32'h00000000);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'h10, 32'hFFFFFFFF, 4'hF);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(8'h10, 32'h00000000);
        `CHK("resets", 9'h000, rv)
        $display("test unmapped and frozen done");
        wr(8'h10, 32'hFFFFFFFF, 4'hF);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk_reset();
        $display("test second reset done");
        end_sim();
    end
endmodule : testbench
